// [dcw_pkg.sv]
`default_nettype none
package dcw_pkg;
   localparam logic [15:0] DCW_CMD_WORD_ADDR = 16'h2000;
   localparam logic [15:0] DCW_CMD_WORD_RST = 16'h0000;
   localparam int DCW_RUN_LSB = 0;
   localparam int DCW_RSVD_LSB = 2;
   localparam int DCW_DIR_LSB = 4;
   localparam int DCW_ACC_LSB = 6;
   localparam int DCW_STEP_LSB = 8;
   localparam int DCW_EXT_EN_BIT = 12;
   localparam logic [1:0] DCW_RUN_NOP = 2'h0;
   localparam logic [1:0] DCW_RUN_STOP = 2'h1;
   localparam logic [1:0] DCW_RUN_RUN = 2'h2;
   localparam logic [1:0] DCW_RUN_JOG = 2'h3;
   localparam logic [1:0] DCW_DIR_FWD = 2'h1;
   localparam logic [1:0] DCW_DIR_REV = 2'h2;
   localparam logic [1:0] DCW_ACC_RST = 2'h0;
   localparam logic [3:0] DCW_STEP_MASTER = 4'h0;

   typedef enum logic [1:0] {DCW_M_STOP, DCW_M_RUN, DCW_M_JOG} dcw_mode_t;

   typedef struct packed {
      logic [15:0] word;
      dcw_mode_t mode;
      logic dir_rev;
      logic [1:0] acc_set;
      logic [3:0] step_sel;
      logic upd;
      logic ack;
      logic err;
   } dcw_state_t;
endpackage : dcw_pkg
`default_nettype wire

// [dcw_decoder.sv]
// Function
// RULE_01: bits 1..0: 00 nothing, 01 stop, 10 run, 11 enable jog.
// RULE_02: bits 3..2 reserved; no effect; master keeps them zero.
// RULE_03: bits 5..4: 01 forward, 10 reverse, 00 and 11 nothing.
// RULE_04: bits 7..6 pick acceleration/deceleration set one to four.
// RULE_05: bits 11..8: zero is master speed, n is preset step n.
// RULE_06: bits 11..6 take effect only when bit 12 is one.
// RULE_07: master writes the whole 16-bit word in one register write.
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder
   import dcw_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_ack_out,
   output logic reg_err_out,
   output logic run_out,
   output logic jog_out,
   output logic dir_rev_out,
   output logic [1:0] acc_set_out,
   output logic [3:0] step_sel_out,
   output logic cmd_upd_out
);
   dcw_state_t s_q, s_d;
   logic hit;
   logic [15:0] w;

   function automatic logic [1:0] fld2(input logic [15:0] v, input int lsb);
      fld2 = v[lsb +: 2];
   endfunction : fld2

   always_comb begin
      s_d = s_q;
      w = reg_wdata_in;
      hit = (reg_addr_in == DCW_CMD_WORD_ADDR);
      s_d.upd = 1'b0;
      s_d.ack = reg_wr_in | reg_rd_in;
      s_d.err = (reg_wr_in | reg_rd_in) & ~hit;
      if (reg_wr_in && hit) begin
         // whole word taken at once; fields never mix two writes  see RULE_07
         s_d.word = w;
         s_d.upd = 1'b1;
         unique case (fld2(w, DCW_RUN_LSB)) // see RULE_01
            DCW_RUN_STOP: s_d.mode = DCW_M_STOP;
            DCW_RUN_RUN: s_d.mode = DCW_M_RUN;
            DCW_RUN_JOG: s_d.mode = DCW_M_JOG;
            DCW_RUN_NOP: s_d.mode = s_q.mode;
         endcase
         // bits 3..2 are stored for readback only  see RULE_02
         if (fld2(w, DCW_DIR_LSB) == DCW_DIR_FWD) begin // see RULE_03
            s_d.dir_rev = 1'b0;
         end else if (fld2(w, DCW_DIR_LSB) == DCW_DIR_REV) begin
            s_d.dir_rev = 1'b1;
         end
         // without the enable the last selections are kept  see RULE_06
         if (w[DCW_EXT_EN_BIT]) begin
            s_d.acc_set = fld2(w, DCW_ACC_LSB); // see RULE_04
            s_d.step_sel = w[DCW_STEP_LSB +: 4]; // see RULE_05
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '{
            word: DCW_CMD_WORD_RST,
            mode: DCW_M_STOP,
            dir_rev: 1'b0,
            acc_set: DCW_ACC_RST,
            step_sel: DCW_STEP_MASTER,
            upd: 1'b0,
            ack: 1'b0,
            err: 1'b0
         };
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_out = s_q.word;
   assign reg_ack_out = s_q.ack;
   assign reg_err_out = s_q.err;
   assign run_out = (s_q.mode == DCW_M_RUN);
   assign jog_out = (s_q.mode == DCW_M_JOG);
   assign dir_rev_out = s_q.dir_rev;
   assign acc_set_out = s_q.acc_set;
   assign step_sel_out = s_q.step_sel;
   assign cmd_upd_out = s_q.upd;

   logic wr_hit;
   assign wr_hit = reg_wr_in && (reg_addr_in == DCW_CMD_WORD_ADDR);

   property p_run_stop;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit |=> (run_out == (($past(reg_wdata_in[1:0]) == 2'h2) ||
                  ($past(reg_wdata_in[1:0]) == 2'h0 && $past(run_out))))
                 && (jog_out == (($past(reg_wdata_in[1:0]) == 2'h3) ||
                  ($past(reg_wdata_in[1:0]) == 2'h0 && $past(jog_out))));
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("run/jog decode wrong"); // see RULE_01

   property p_rsvd;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (wr_hit && reg_wdata_in[3:2] != 2'h0) |=> (cmd_upd_out && reg_rdata_out[3:2] != 2'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not stored"); // see RULE_02

   property p_dir;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit |=> dir_rev_out == (($past(reg_wdata_in[5:4]) == 2'h2) ||
                 ($past(reg_wdata_in[5:4]) != 2'h1 && $past(dir_rev_out)));
   endproperty
   a_dir: assert property (p_dir) else $error("direction decode wrong"); // see RULE_03

   property p_acc;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (wr_hit && reg_wdata_in[12]) ##1 !wr_hit[*2] |-> acc_set_out == $past(reg_wdata_in[7:6], 2);
   endproperty
   a_acc: assert property (p_acc) else $error("accel set not taken"); // see RULE_04

   property p_step;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (wr_hit && reg_wdata_in[12]) |=> step_sel_out == $past(reg_wdata_in[11:8]);
   endproperty
   a_step: assert property (p_step) else $error("step select not taken"); // see RULE_05

   property p_hold;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (wr_hit && !reg_wdata_in[12]) |=> $stable(acc_set_out) && $stable(step_sel_out);
   endproperty
   a_hold: assert property (p_hold) else $error("fields 11..6 changed without enable"); // see RULE_06

   property p_upd;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit |=> cmd_upd_out && reg_ack_out && !reg_err_out;
   endproperty
   a_upd: assert property (p_upd) else $error("write not acknowledged"); // see RULE_07

   // two low edges so the asynchronous clear has surely landed
   property p_rst;
      @(posedge mclk_in)
      !rst_b_in ##1 !rst_b_in |->
         reg_rdata_out == DCW_CMD_WORD_RST
         && !run_out
         && !jog_out
         && !dir_rev_out
         && acc_set_out == DCW_ACC_RST
         && step_sel_out == DCW_STEP_MASTER
         && !reg_ack_out
         && !reg_err_out
         && !cmd_upd_out;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong"); // see RULE_01

   // reads and refused writes must leave every decoded field alone
   property p_idle;
      @(posedge mclk_in) disable iff (!rst_b_in)
      !wr_hit |=>
         $stable(reg_rdata_out)
         && $stable(run_out)
         && $stable(jog_out)
         && $stable(dir_rev_out)
         && $stable(acc_set_out)
         && $stable(step_sel_out);
   endproperty
   a_idle: assert property (p_idle) else $error("state moved without a write"); // see RULE_07

   property p_err;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (reg_wr_in || reg_rd_in) && reg_addr_in != DCW_CMD_WORD_ADDR |=>
         reg_ack_out
         && reg_err_out
         && !cmd_upd_out;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused"); // see RULE_07

   property p_quiet;
      @(posedge mclk_in) disable iff (!rst_b_in)
      !(reg_wr_in || reg_rd_in) |=>
         !reg_ack_out
         && !reg_err_out
         && !cmd_upd_out;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without a request"); // see RULE_07

   property p_word;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit |=> reg_rdata_out == $past(reg_wdata_in);
   endproperty
   a_word: assert property (p_word) else $error("stored word differs"); // see RULE_07

   property p_upd_src;
      @(posedge mclk_in) disable iff (!rst_b_in)
      cmd_upd_out |-> $past(wr_hit);
   endproperty
   a_upd_src: assert property (p_upd_src) else $error("stray update pulse"); // see RULE_07

   // no-function codes and reserved bits alone must change nothing
   property p_rsvd_free;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit
         && reg_wdata_in[DCW_RUN_LSB +: 2] == DCW_RUN_NOP
         && reg_wdata_in[DCW_DIR_LSB +: 2] == 2'h0
         && !reg_wdata_in[DCW_EXT_EN_BIT] |=>
         $stable(run_out)
         && $stable(jog_out)
         && $stable(dir_rev_out)
         && $stable(acc_set_out)
         && $stable(step_sel_out);
   endproperty
   a_rsvd_free: assert property (p_rsvd_free) else $error("idle codes acted"); // see RULE_02

   c_run: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $rose(run_out));
   c_jog_rev: cover property (@(posedge mclk_in) disable iff (!rst_b_in) jog_out && dir_rev_out);
   c_step: cover property (@(posedge mclk_in) disable iff (!rst_b_in) step_sel_out == 4'hf);
   c_err: cover property (@(posedge mclk_in) disable iff (!rst_b_in) reg_err_out);
   c_keep: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
      wr_hit && !reg_wdata_in[DCW_EXT_EN_BIT]);
endmodule : dcw_decoder
`default_nettype wire

// [dcw_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dcw_master_model (
   input wire logic mclk_in,
   input wire logic ack_in,
   input wire logic err_in,
   output logic wr_out,
   output logic rd_out,
   output logic [15:0] addr_out,
   output logic [15:0] wdata_out
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 16'h0000;
      wdata_out = 16'h0000;
   end
   // whole word in one request, answer taken at the falling edge after the taking edge
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
         output logic ack, output logic err);
      @(negedge mclk_in);
      wr_out = w;
      rd_out = !w;
      addr_out = a;
      wdata_out = d;
      @(negedge mclk_in);
      ack = ack_in;
      err = err_in;
      wr_out = 1'b0;
      rd_out = 1'b0;
      // released lines flip so a stale value can never look valid
      addr_out = ~a;
      wdata_out = ~d;
   endtask : xfer
endmodule : dcw_master_model
`default_nettype wire

// [dcw_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder_tb;
   import dcw_pkg::*;
   logic mclk_in = 1'b0, rst_b_in = 1'b0, wr, rd, ack, err, upd, run, jog, rev, k_a, k_e;
   logic [15:0] addr, wd, rdata, e_w;
   logic [1:0] acc, e_acc;
   logic [3:0] stp, e_stp;
   logic e_run, e_jog, e_rev;
   int err_total = 0, total_checks = 0;
   initial forever #12.5 mclk_in = ~mclk_in;
   dcw_master_model i_dcw_master_model (.mclk_in(mclk_in), .ack_in(ack), .err_in(err),
      .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
   dcw_decoder i_dcw_decoder (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
      .reg_ack_out(ack), .reg_err_out(err), .run_out(run), .jog_out(jog), .dir_rev_out(rev),
      .acc_set_out(acc), .step_sel_out(stp), .cmd_upd_out(upd));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic st();
      chk("state", {e_w, e_run, e_jog, e_rev, e_acc, e_stp, 7'h00},
         {rdata, run, jog, rev, acc, stp, 7'h00});
   endtask : st
   task automatic put(input logic [15:0] a, input logic [15:0] d);
      i_dcw_master_model.xfer(1'b1, a, d, k_a, k_e);
      chk("ack_err_upd", {29'h0, 1'b1, a != 16'h2000, a == 16'h2000},
         {29'h0, k_a, k_e, upd});
      if (a == 16'h2000) begin
         e_w = d;
         // code 00 keeps the running mode
         if (d[1:0] != 2'h0) begin
            e_run = (d[1:0] == 2'h2);
            e_jog = (d[1:0] == 2'h3);
         end
         if (d[5:4] == 2'h1 || d[5:4] == 2'h2) e_rev = d[5];
         if (d[12]) begin
            e_acc = d[7:6];
            e_stp = d[11:8];
         end
      end
      st();
   endtask : put
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      {e_w, e_run, e_jog, e_rev, e_acc, e_stp} = 25'h0;
      repeat (20) @(negedge mclk_in);
      rst_b_in = 1'b1;
      st();
      put(16'h2000, 16'h1246);
      put(16'h2000, 16'h0fd1);
      put(16'h2000, 16'h1fef);
      put(16'h2000, 16'h1030);
      put(16'h2000, 16'h000c);
      put(16'h2000, 16'h1496);
      put(16'h2001, 16'h0002);
      i_dcw_master_model.xfer(1'b0, 16'h2000, 16'h0000, k_a, k_e);
      chk("read", {15'h0, 1'b1, e_w}, {15'h0, k_a & !k_e, rdata});
      i_dcw_master_model.xfer(1'b0, 16'h3000, 16'h0000, k_a, k_e);
      chk("rd_err", {30'h0, 2'h3}, {30'h0, k_a, k_e});
      $display("decode test done");
      rst_b_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      rst_b_in = 1'b1;
      {e_w, e_run, e_jog, e_rev, e_acc, e_stp} = 25'h0;
      st();
      put(16'h2000, 16'h1172);
      $display("reset test done");
      end_sim();
   end
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
endmodule : dcw_decoder_tb
`default_nettype wire
